// >>> imau_pkg.sv
// package for the interrupt mask and flag-clearing unit
// assumes one register port of 8-bit data and 8-bit index, on clk_sys
package imau_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] IMAU_NOTIFY_MASK_OFS  = 8'h07;
  localparam logic [7:0] IMAU_FAULT_MASK_OFS   = 8'h08;
  localparam logic [7:0] IMAU_WARNING_MASK_OFS = 8'h09;
  localparam logic [7:0] IMAU_NOTIFY_FLAG_OFS  = 8'h0A;
  localparam logic [7:0] IMAU_FAULT_FLAG_OFS   = 8'h0B;
  localparam logic [7:0] IMAU_WARNING_FLAG_OFS = 8'h0C;

  // ==========================================================================
  // notify mask fields
  localparam int IMAU_AUTO_CLEAR_BIT    = 7;
  localparam int IMAU_TC_STATE_BIT      = 5;
  localparam int IMAU_TC_ATT_STAT_BIT   = 4;
  localparam int IMAU_BC_ATT_STAT_BIT   = 3;
  localparam int IMAU_TC_ATT_EVENT_BIT  = 2;
  localparam int IMAU_BC_ATT_EVENT_BIT  = 1;
  localparam int IMAU_ADC_DONE_BIT      = 0;

  // ==========================================================================
  // fault mask fields
  localparam int IMAU_PRE_OV_BIT        = 6;
  localparam int IMAU_LIM_UV_BIT        = 5;
  localparam int IMAU_ILIM_BIT          = 4;
  localparam int IMAU_BUS_OV_BIT        = 3;
  localparam int IMAU_BUS_UV_BIT        = 2;
  localparam int IMAU_SHORT_GND_BIT     = 1;
  localparam int IMAU_THERM_SHD_BIT     = 0;

  // ==========================================================================
  // warning mask fields
  localparam int IMAU_PREBIAS_BIT       = 5;
  localparam int IMAU_THERM_WARN_BIT    = 3;
  localparam int IMAU_IN_OV_BIT         = 2;
  localparam int IMAU_DATA_OV_BIT       = 1;

  // ==========================================================================
  // writable bits and reset values
  localparam logic [7:0] IMAU_NOTIFY_WMASK  = 8'hBF;
  localparam logic [7:0] IMAU_FAULT_WMASK   = 8'h7F;
  localparam logic [7:0] IMAU_WARNING_WMASK = 8'h2E;
  localparam logic [7:0] IMAU_MASK_RESET    = 8'h00;
  localparam logic [7:0] IMAU_FLAG_RESET    = 8'h00;

  // notify flags whose clear is by read alone
  localparam logic [7:0] IMAU_NOTIFY_EVENT_ONLY = 8'h26;
  // notify flags given as READ_CLR; the flag bank ignores it, so a live condition still re-sets them on read
  localparam logic [7:0] IMAU_NOTIFY_READ_CLR   = 8'h27;

endpackage

// >>> imau_flag_bank.sv
// one bank of eight sticky flags with read clear and optional auto clear
// assumes condition inputs already synchronised to clk_sys
`timescale 1ns/100ps
`default_nettype none
module imau_flag_bank #(
  parameter logic [7:0] VALID_BITS  = 8'hFF,
  parameter logic [7:0] READ_CLR    = 8'h00,
  parameter logic [7:0] NO_AUTO_CLR = 8'h00
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [7:0] cond,
  input  wire logic       rd_clear,
  input  wire logic       auto_clear,
  output logic      [7:0] flags_reg
);
  import imau_pkg::*;

  logic [7:0] flags_next;

  // ==========================================================================
  // per-bit flag update
  generate
    for (genvar i = 0; i < 8; i++) begin : g_bit
      always_comb begin
        if (!VALID_BITS[i]) begin
          flags_next[i] = 1'b0;
        end else if (cond[i]) begin
          // set wins over any clear in the same cycle
          flags_next[i] = 1'b1;
        end else if (auto_clear && !NO_AUTO_CLR[i]) begin
          flags_next[i] = 1'b0;
        end else if (rd_clear) begin
          // fault flags reach here only with the condition gone
          flags_next[i] = 1'b0;
        end else begin
          flags_next[i] = flags_reg[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= IMAU_FLAG_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule
`default_nettype wire

// >>> imau_irq_unit.sv
// interrupt mask and flag-clearing unit: mask registers, flags, irq output
// assumes a synchronous register port on clk_sys; conditions come from pins
//
// Function
// - notify mask bit 7 selects auto clear of flags; resets to 0.
// - enable bit 1 includes its flag in interrupt; all reset to 0.
// - mask 0x7 gates notifications; bit 5 state change, bit 0 adc done.
// - notify mask bit 4 enables Type-C attach status flag.
// - notify mask bit 3 enables BC1.2 attach status flag.
// - notify mask bit 2 enables Type-C attach event flag.
// - notify mask bit 1 enables BC1.2 attach event flag.
// - mask 0x8 gates seven fault flags, bits 6 down to 0.
// - mask 0x9 gates warnings at bits 5,3,2,1; others unused.
// - state change and attach event flags clear only on read.
// - fault flag read clears it only when its condition is gone.
`timescale 1ns/100ps
`default_nettype none
module imau_irq_unit (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] notify_cond,
  input  wire logic [7:0] fault_cond,
  input  wire logic [7:0] warning_cond,
  output logic            irq_out
);
  import imau_pkg::*;

  // ==========================================================================
  // input synchronisers
  logic [7:0] notify_s1_reg, notify_s2_reg;
  logic [7:0] fault_s1_reg, fault_s2_reg;
  logic [7:0] warning_s1_reg, warning_s2_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      notify_s1_reg  <= 8'h00;
      notify_s2_reg  <= 8'h00;
      fault_s1_reg   <= 8'h00;
      fault_s2_reg   <= 8'h00;
      warning_s1_reg <= 8'h00;
      warning_s2_reg <= 8'h00;
    end else begin
      notify_s1_reg  <= notify_cond;
      notify_s2_reg  <= notify_s1_reg;
      fault_s1_reg   <= fault_cond;
      fault_s2_reg   <= fault_s1_reg;
      warning_s1_reg <= warning_cond;
      warning_s2_reg <= warning_s1_reg;
    end
  end

  // ==========================================================================
  // mask registers
  logic [7:0] notify_interrupt_mask_reg, notify_interrupt_mask_next;
  logic [7:0] fault_interrupt_mask_reg, fault_interrupt_mask_next;
  logic [7:0] warning_interrupt_mask_reg, warning_interrupt_mask_next;
  logic       flag_auto_clear;

  always_comb begin
    notify_interrupt_mask_next  = notify_interrupt_mask_reg;
    fault_interrupt_mask_next   = fault_interrupt_mask_reg;
    warning_interrupt_mask_next = warning_interrupt_mask_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        IMAU_NOTIFY_MASK_OFS: begin
          notify_interrupt_mask_next = reg_wdata & IMAU_NOTIFY_WMASK;
        end
        IMAU_FAULT_MASK_OFS: begin
          fault_interrupt_mask_next = reg_wdata & IMAU_FAULT_WMASK;
        end
        IMAU_WARNING_MASK_OFS: begin
          warning_interrupt_mask_next = reg_wdata & IMAU_WARNING_WMASK;
        end
        default: begin
          // other offsets belong to other blocks
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      notify_interrupt_mask_reg  <= IMAU_MASK_RESET;
      fault_interrupt_mask_reg   <= IMAU_MASK_RESET;
      warning_interrupt_mask_reg <= IMAU_MASK_RESET;
    end else begin
      notify_interrupt_mask_reg  <= notify_interrupt_mask_next;
      fault_interrupt_mask_reg   <= fault_interrupt_mask_next;
      warning_interrupt_mask_reg <= warning_interrupt_mask_next;
    end
  end

  assign flag_auto_clear = notify_interrupt_mask_reg[IMAU_AUTO_CLEAR_BIT];

  // named enables
  logic typec_state_change_enable, typec_attach_status_enable;
  logic bc12_attach_status_enable, typec_attach_event_enable;
  logic bc12_attach_event_enable;
  assign typec_state_change_enable  = notify_interrupt_mask_reg[IMAU_TC_STATE_BIT];
  assign typec_attach_status_enable = notify_interrupt_mask_reg[IMAU_TC_ATT_STAT_BIT];
  assign bc12_attach_status_enable  = notify_interrupt_mask_reg[IMAU_BC_ATT_STAT_BIT];
  assign typec_attach_event_enable  = notify_interrupt_mask_reg[IMAU_TC_ATT_EVENT_BIT];
  assign bc12_attach_event_enable   = notify_interrupt_mask_reg[IMAU_BC_ATT_EVENT_BIT];

  // ==========================================================================
  // flag banks
  logic       rd_notify, rd_fault, rd_warning;
  logic [7:0] notify_flags, fault_flags, warning_flags;

  assign rd_notify  = reg_rd && (reg_addr == IMAU_NOTIFY_FLAG_OFS);
  assign rd_fault   = reg_rd && (reg_addr == IMAU_FAULT_FLAG_OFS);
  assign rd_warning = reg_rd && (reg_addr == IMAU_WARNING_FLAG_OFS);

  // events are clear-on-read only, so auto clear never touches them
  imau_flag_bank #(
    .VALID_BITS  (IMAU_NOTIFY_WMASK & 8'h7F),
    .READ_CLR    (IMAU_NOTIFY_READ_CLR),
    .NO_AUTO_CLR (IMAU_NOTIFY_EVENT_ONLY)
  ) u_notify (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond       (notify_s2_reg),
    .rd_clear   (rd_notify),
    .auto_clear (flag_auto_clear),
    .flags_reg  (notify_flags)
  );

  // a live fault re-sets its flag, so a read cannot clear it
  imau_flag_bank #(
    .VALID_BITS  (IMAU_FAULT_WMASK),
    .READ_CLR    (IMAU_FAULT_WMASK),
    .NO_AUTO_CLR (8'h00)
  ) u_fault (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond       (fault_s2_reg),
    .rd_clear   (rd_fault),
    .auto_clear (flag_auto_clear),
    .flags_reg  (fault_flags)
  );

  imau_flag_bank #(
    .VALID_BITS  (IMAU_WARNING_WMASK),
    .READ_CLR    (IMAU_WARNING_WMASK),
    .NO_AUTO_CLR (8'h00)
  ) u_warning (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond       (warning_s2_reg),
    .rd_clear   (rd_warning),
    .auto_clear (flag_auto_clear),
    .flags_reg  (warning_flags)
  );

  // ==========================================================================
  // interrupt and read data
  logic       irq_next;
  logic [7:0] notify_gate;
  logic [7:0] rdata_next;

  always_comb begin
    notify_gate = notify_flags & notify_interrupt_mask_reg & 8'h7F;
    notify_gate[IMAU_TC_STATE_BIT]     = notify_flags[IMAU_TC_STATE_BIT]
                                         & typec_state_change_enable;
    notify_gate[IMAU_TC_ATT_STAT_BIT]  = notify_flags[IMAU_TC_ATT_STAT_BIT]
                                         & typec_attach_status_enable;
    notify_gate[IMAU_BC_ATT_STAT_BIT]  = notify_flags[IMAU_BC_ATT_STAT_BIT]
                                         & bc12_attach_status_enable;
    notify_gate[IMAU_TC_ATT_EVENT_BIT] = notify_flags[IMAU_TC_ATT_EVENT_BIT]
                                         & typec_attach_event_enable;
    notify_gate[IMAU_BC_ATT_EVENT_BIT] = notify_flags[IMAU_BC_ATT_EVENT_BIT]
                                         & bc12_attach_event_enable;
    irq_next = (|notify_gate)
             | (|(fault_flags & fault_interrupt_mask_reg))
             | (|(warning_flags & warning_interrupt_mask_reg));
  end

  always_comb begin
    unique case (reg_addr)
      IMAU_NOTIFY_MASK_OFS:  rdata_next = notify_interrupt_mask_reg;
      IMAU_FAULT_MASK_OFS:   rdata_next = fault_interrupt_mask_reg;
      IMAU_WARNING_MASK_OFS: rdata_next = warning_interrupt_mask_reg;
      IMAU_NOTIFY_FLAG_OFS:  rdata_next = notify_flags;
      IMAU_FAULT_FLAG_OFS:   rdata_next = fault_flags;
      IMAU_WARNING_FLAG_OFS: rdata_next = warning_flags;
      default:               rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_out   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      irq_out   <= irq_next;
      reg_rdata <= reg_rd ? rdata_next : reg_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> imau_irq_assertions.sv
// checker for the irq mask unit, port-level properties only
// assumes a bind onto imau_irq_unit and a single clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module imau_irq_assertions
  import imau_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] fault_cond,
  input wire logic       irq_out
);
  // ==========================================================================
  // mask shadows rebuilt from the write port
  logic [7:0] sh0_reg, sh1_reg, sh2_reg;
  logic       quiet, ev_only, no_mask;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sh0_reg <= 8'h00;
      sh1_reg <= 8'h00;
      sh2_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == IMAU_NOTIFY_MASK_OFS) sh0_reg <= reg_wdata & IMAU_NOTIFY_WMASK;
      if (reg_addr == IMAU_FAULT_MASK_OFS) sh1_reg <= reg_wdata & IMAU_FAULT_WMASK;
      if (reg_addr == IMAU_WARNING_MASK_OFS) sh2_reg <= reg_wdata & IMAU_WARNING_WMASK;
    end
  end
  assign quiet   = !reg_wr && !reg_rd;
  assign ev_only = sh1_reg == 8'h00 && sh2_reg == 8'h00 && (sh0_reg & 8'h19) == 8'h00;
  assign no_mask = (sh0_reg & 8'h7F) == 8'h00 && sh1_reg == 8'h00 && sh2_reg == 8'h00;
  // ==========================================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_reset_quiet; $rose(rstn) |-> !irq_out ##1 !irq_out; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("irq after reset");
  property p_all_masked; (no_mask[*3]) |-> !irq_out; endproperty
  a_all_masked: assert property (p_all_masked) else $error("irq with no enable");
  property p_notify_read; reg_rd && reg_addr == 8'h07 |=> reg_rdata == $past(sh0_reg); endproperty
  a_notify_read: assert property (p_notify_read) else $error("notify mask readback");
  property p_autoclr_read;
    reg_rd && reg_addr == 8'h07 && !sh0_reg[7] |=> !reg_rdata[7];
  endproperty
  a_autoclr_read: assert property (p_autoclr_read) else $error("auto clear readback");
  property p_fault_read; reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(sh1_reg); endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault mask readback");
  property p_warn_read; reg_rd && reg_addr == 8'h09 |=> reg_rdata == $past(sh2_reg); endproperty
  a_warn_read: assert property (p_warn_read) else $error("warning mask readback");
  // event flags survive auto clear, so only a read or a mask write may drop this irq
  property p_event_hold; (quiet[*3]) ##0 (ev_only && irq_out) |=> irq_out; endproperty
  a_event_hold: assert property (p_event_hold) else $error("event irq dropped");
  property p_fault_hold; ((fault_cond & sh1_reg) != 8'h00)[*5] ##0 !reg_wr |=> irq_out; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("live fault irq low");
endmodule
bind imau_irq_unit imau_irq_assertions imau_irq_assertions_i (.clk_sys, .rstn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .fault_cond, .irq_out);
`default_nettype wire

// >>> imau_host_model.sv
// host model: single-cycle strobe master of the irq unit register port
// assumes reg_rdata is registered on the edge that samples reg_rd
`timescale 1ns/100ps
`default_nettype none
module imau_host_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // idle wdata after a write and idle addr after a read show inverted junk
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> irq_mask_autoclear_unit_bench.sv
// self-checking bench for the irq mask unit against a behavioural model
// assumes imau_host_model as register master and the bound checker
`timescale 1ns/100ps
`default_nettype none
module irq_mask_autoclear_unit_bench;
  import imau_pkg::*;
  localparam int VALID [3] = '{8'h3F, 8'h7F, 8'h2E};
  localparam int WM [3]    = '{IMAU_NOTIFY_WMASK, IMAU_FAULT_WMASK, IMAU_WARNING_WMASK};
  logic       clk_sys, rstn, reg_wr, reg_rd, irq_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data, d;
  logic [7:0] cond [3];
  int         n_fail, check_count, seed, i, k;
  int         msk [3];
  int         flg [3];
  imau_irq_unit imau_irq_unit_i (.clk_sys, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .notify_cond(cond[0]), .fault_cond(cond[1]), .warning_cond(cond[2]), .irq_out);
  imau_host_model host_i (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // compare tasks and model steps
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  // six cycles covers sync, flag and irq register stages
  task automatic settle();
    int e;
    e = 0;
    repeat (6) @(posedge clk_sys);
    for (int j = 0; j < 3; j++) begin
      flg[j] |= cond[j] & VALID[j];
      if (msk[0][7]) flg[j] &= cond[j] | (j == 0 ? 8'h26 : 8'h00);
      e |= flg[j] & msk[j];
    end
    #1 check_bit("irq_out", e != 0, irq_out);
  endtask
  task automatic read_all();
    for (int j = 0; j < 3; j++) begin
      host_i.read_reg(8'(IMAU_NOTIFY_MASK_OFS + j), rd_data);
      check_byte("mask", 8'(msk[j]), rd_data);
    end
    for (int j = 0; j < 3; j++) begin
      host_i.read_reg(8'(IMAU_NOTIFY_FLAG_OFS + j), rd_data);
      check_byte("flags", 8'(flg[j]), rd_data);
      flg[j] &= cond[j];
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    test_done();
  end
  // ==========================================================================
  // main sequence
  initial begin
    rstn        = 1'b0;
    cond        = '{default: 8'h00};
    msk         = '{default: 0};
    flg         = '{default: 0};
    n_fail      = 0;
    check_count = 0;
    seed        = 32'h7cc3_87b6;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    host_i.write_reg(8'h06, 8'hFF);
    read_all();
    host_i.read_reg(8'h0D, rd_data);
    check_byte("unmapped", 8'h00, rd_data);
    for (i = 0; i < 16; i++) begin
      // first two passes: events with auto clear, then faults alone
      for (k = 0; k < 3; k++) begin
        d = 8'($random(seed));
        if (i == 0) d = (k == 0) ? 8'h86 : 8'h00;
        if (i == 1) d = (k == 1) ? 8'h7F : 8'h00;
        host_i.write_reg(8'(IMAU_NOTIFY_MASK_OFS + k), d);
        msk[k] = d & WM[k];
      end
      @(posedge clk_sys);
      for (k = 0; k < 3; k++) cond[k] <= 8'($random(seed)) | ((i == k) ? 8'h07 : 8'h00);
      settle();
      read_all();
      @(posedge clk_sys);
      for (k = 0; k < 3; k++) cond[k] <= cond[k] & 8'($random(seed));
      settle();
      read_all();
    end
    // mid-run reset: masks and flags must return to zero
    for (k = 0; k < 3; k++) cond[k] <= 8'h00;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    msk = '{default: 0};
    flg = '{default: 0};
    settle();
    read_all();
    test_done();
  end
endmodule
`default_nettype wire
